// ==== core/pfs_output_select.sv ====
// programmable output function selector for one digital output
//
// Notes on behaviour
// R1 - code 5: rising crossing of words 2-3 threshold, hold for words 4-5 ms
// R2 - position functions use commanded position if bit 14 set, else actual
// R3 - code 0 follows selected event bits, code 2 follows manual output bit
// R4 - code 7: like code 5 but crossing in either direction triggers
// R5 - code 8: active while phase angle plus offset lies in 0 to 180 degrees
// R6 - phase offset comes from extra word 1, in degrees
// R7 - code 9: pulse whenever position crosses any of the first tblCount entries of the position table
// R8 - code 10: output switches the external regen resistor
// R9 - code 11: pulse output on every fieldbus sync event
// R10 - code 12: active while a fieldbus frame is being received
// R11 - code 13: active from capture status bits selected by words 2-3 mask
// R12 - code 13 with bit 14: tracked capture bits cleared when output goes active
// R13 - code 13 auto-clear: words 4-5 give pulse length in ms
// R14 - code 13 auto-clear with zero length: pulse lasts one servo cycle
// R15 - code 16: output follows hardware position compare result
// R16 - code 17: selected event bit set gives active unless bit 14 set
// R17 - code 17: else manual bit set gives active unless bit 15 set
// R18 - code 17: otherwise output active exactly when bit 15 set
// R19 - code 18: brake active for delay, then switched with on and off times
// R20 - brake switching on-time from word 2 in microseconds
// R21 - brake period word 3 us, word 4 reserved, delay word 5 ms
// R22 - undefined codes keep the output inactive
`include "pfs_defines.svh"

module pfs_output_select #(
    parameter int MS_CYCLES = `PFS_MS_CYCLES,
    parameter int US_CYCLES = `PFS_US_CYCLES,
    parameter int TBL_DEPTH = 8,
    parameter int TBL_AW = 3
) (
    // clock, reset, enable
    input wire logic clk,
    input wire logic rst,
    input wire logic clkEn,
    // configuration
    input wire logic [15:0] cfgWord,
    input wire logic [15:0] extraWord1,
    input wire logic [15:0] extraWord2,
    input wire logic [15:0] extraWord3,
    input wire logic [15:0] extraWord4,
    input wire logic [15:0] extraWord5,
    // servo timebase and positions
    input wire logic servoTick,
    input wire logic [31:0] cmdPos,
    input wire logic [31:0] actPos,
    input wire logic [8:0] phaseDeg,
    // status sources on this clock
    input wire logic [31:0] eventStatus,
    input wire logic [31:0] latchedStatus,
    input wire logic [31:0] trajStatus,
    input wire logic [31:0] captureStatus,
    input wire logic manualOut,
    input wire logic regenReq,
    input wire logic brakeReq,
    // position table writes
    input wire logic tblWrEn,
    input wire logic [TBL_AW-1:0] tblWrAddr,
    input wire logic [31:0] tblWrData,
    input wire logic [TBL_AW:0] tblCount,
    // asynchronous pins
    input wire logic syncPin,
    input wire logic frameRxPin,
    input wire logic compareHitPin,
    // results
    output logic outActive,
    output logic [31:0] captureClear
);

    ////////////////////////////////////////////////////////////////////////
    // constants and decoded configuration

    localparam logic [31:0] MS_LAST = 32'(MS_CYCLES - 1);
    localparam logic [31:0] US_LAST = 32'(US_CYCLES - 1);

    wire logic [4:0] func = cfgWord[`PFS_FUNC_MSB:`PFS_FUNC_LSB];
    wire logic bit14 = cfgWord[`PFS_BIT_ALT1];
    wire logic bit15 = cfgWord[`PFS_BIT_ALT2];
    wire logic [31:0] words23 = {extraWord3, extraWord2};
    wire logic [31:0] words45 = {extraWord5, extraWord4};

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers

    logic [2:0] pinMeta_q;
    logic [2:0] pinSync_q;
    logic syncPrev_q;

    always_ff @(posedge clk) begin
        if (rst) begin
            pinMeta_q <= 3'h0;
            pinSync_q <= 3'h0;
            syncPrev_q <= 1'b0;
        end else if (clkEn) begin
            pinMeta_q <= {compareHitPin, frameRxPin, syncPin};
            pinSync_q <= pinMeta_q;
            syncPrev_q <= pinSync_q[0];
        end
    end

    wire logic syncRise = pinSync_q[0] & ~syncPrev_q;

    ////////////////////////////////////////////////////////////////////////
    // microsecond and millisecond ticks

    logic [31:0] usDiv_q;
    logic [31:0] msDiv_q;
    wire logic usTick = (usDiv_q == US_LAST);
    wire logic msTick = (msDiv_q == MS_LAST);

    always_ff @(posedge clk) begin
        if (rst) begin
            usDiv_q <= 32'h0;
            msDiv_q <= 32'h0;
        end else if (clkEn) begin
            usDiv_q <= usTick ? 32'h0 : usDiv_q + 32'h1;
            msDiv_q <= msTick ? 32'h0 : msDiv_q + 32'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // position selection and crossing detection

    logic [31:0] prevPos_q;
    logic posValid_q;

    wire logic [31:0] curPos = bit14 ? cmdPos : actPos; // [R2]
    wire logic signed [31:0] posNow = $signed(curPos);
    wire logic signed [31:0] posOld = $signed(prevPos_q);
    wire logic signed [31:0] thr = $signed(words23);
    wire logic crossUp = posValid_q && (posOld < thr) && (posNow >= thr);
    wire logic crossDn = posValid_q && (posOld > thr) && (posNow <= thr);
    wire logic inWindow = (posNow >= thr) && (posNow <= $signed(words45));

    always_ff @(posedge clk) begin
        if (rst) begin
            prevPos_q <= 32'h0;
            posValid_q <= 1'b0;
        end else if (clkEn && servoTick) begin
            prevPos_q <= curPos;
            posValid_q <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // position table held in trace memory

    logic [31:0] tblMem_q [TBL_DEPTH];
    logic [TBL_DEPTH-1:0] tblHitVec;

    always_ff @(posedge clk) begin
        if (clkEn && tblWrEn) begin
            tblMem_q[tblWrAddr] <= tblWrData;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < TBL_DEPTH; gi++) begin : gTbl
            wire logic signed [31:0] ent = $signed(tblMem_q[gi]);
            wire logic used = (tblCount > (TBL_AW + 1)'(gi));
            assign tblHitVec[gi] = used && posValid_q &&
                (((posOld < ent) && (posNow >= ent)) || ((posOld > ent) && (posNow <= ent))); // [R7]
        end
    endgenerate

    wire logic tblHit = |tblHitVec;

    ////////////////////////////////////////////////////////////////////////
    // timed pulses for crossings, table and capture

    logic [31:0] pulseMs_q;
    logic servoPulse_q;
    wire logic pulseBusy = servoPulse_q | (pulseMs_q != 32'h0);

    wire logic crossTrig = servoTick && (
        ((func == pfs_pkg::FN_CROSS_UP) && crossUp) || // [R1]
        ((func == pfs_pkg::FN_CROSS_DN) && crossDn) ||
        ((func == pfs_pkg::FN_CROSS_ANY) && (crossUp || crossDn))); // [R4]
    wire logic tblTrig = servoTick && (func == pfs_pkg::FN_TABLE) && tblHit; // [R7]

    wire logic [31:0] capSel = captureStatus & words23; // [R11]
    wire logic capAny = |capSel;
    wire logic capAuto = (func == pfs_pkg::FN_CAPTURE) && bit14;
    wire logic capTrig = capAuto && capAny && !pulseBusy && !outActive; // [R12]

    wire logic lenTrig = crossTrig || capTrig;
    wire logic oneCycTrig = tblTrig || (lenTrig && (words45 == 32'h0)); // [R14]

    always_ff @(posedge clk) begin
        if (rst) begin
            pulseMs_q <= 32'h0;
        end else if (clkEn) begin
            if (lenTrig && (words45 != 32'h0)) begin
                pulseMs_q <= words45; // [R1] [R13]
            end else if (msTick && (pulseMs_q != 32'h0)) begin
                pulseMs_q <= pulseMs_q - 32'h1;
            end
        end
    end

    // a new trigger on the same servo tick wins over the end of the pulse
    always_ff @(posedge clk) begin
        if (rst) begin
            servoPulse_q <= 1'b0;
        end else if (clkEn) begin
            if (oneCycTrig) begin
                servoPulse_q <= 1'b1; // [R14]
            end else if (servoTick) begin
                servoPulse_q <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // capture bit clearing, pulsed as the output goes active

    always_ff @(posedge clk) begin
        if (rst) begin
            captureClear <= `PFS_CLR_RST;
        end else if (clkEn) begin
            captureClear <= capTrig ? capSel : 32'h0; // [R12]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // motor phase angle window

    wire logic [15:0] offMod = extraWord1 % 16'h0168; // [R6]
    wire logic [9:0] phaseSum = {1'b0, phaseDeg} + offMod[9:0];
    wire logic [9:0] phaseWrap = (phaseSum >= `PFS_DEG_FULL) ? phaseSum - `PFS_DEG_FULL : phaseSum;
    wire logic phaseAct = (phaseWrap < `PFS_DEG_HALF); // [R5]

    ////////////////////////////////////////////////////////////////////////
    // brake with timed switching

    pfs_pkg::pfs_brake_e brkState_q;
    logic [15:0] brkMs_q;
    logic [15:0] brkUs_q;

    wire logic brkSel = (func == pfs_pkg::FN_BRAKE) && brakeReq;
    wire logic brkDelayDone = (brkMs_q == 16'h0);
    wire logic brkPeriodEnd = (brkUs_q >= extraWord3 - 16'h1); // [R21]
    wire logic brkOn = (brkState_q == pfs_pkg::BRK_HOLD) ||
        ((brkState_q == pfs_pkg::BRK_PWM) && ((brkUs_q < extraWord2) || (extraWord3 == 16'h0))); // [R20]

    always_ff @(posedge clk) begin
        if (rst) begin
            brkState_q <= pfs_pkg::BRK_IDLE;
            brkMs_q <= 16'h0;
            brkUs_q <= 16'h0;
        end else if (clkEn) begin
            case (brkState_q)
                pfs_pkg::BRK_IDLE: begin
                    brkUs_q <= 16'h0;
                    if (brkSel) begin
                        brkState_q <= pfs_pkg::BRK_HOLD; // [R19]
                        brkMs_q <= extraWord5; // [R21]
                    end
                end
                pfs_pkg::BRK_HOLD: begin
                    if (!brkSel) begin
                        brkState_q <= pfs_pkg::BRK_IDLE;
                    end else if (brkDelayDone) begin
                        brkState_q <= pfs_pkg::BRK_PWM; // [R19]
                    end else if (msTick) begin
                        brkMs_q <= brkMs_q - 16'h1;
                    end
                end
                pfs_pkg::BRK_PWM: begin
                    if (!brkSel) begin
                        brkState_q <= pfs_pkg::BRK_IDLE;
                    end else if (usTick) begin
                        brkUs_q <= brkPeriodEnd ? 16'h0 : brkUs_q + 16'h1;
                    end
                end
                default: begin
                    brkState_q <= pfs_pkg::BRK_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // function selection

    wire logic evtAny = |(eventStatus & words23);
    wire logic evtMan = evtAny ? ~bit14 : (manualOut ? ~bit15 : bit15); // [R16] [R17] [R18]
    logic outD;

    always_comb begin
        case (func)
            pfs_pkg::FN_EVENT: outD = evtAny; // [R3]
            pfs_pkg::FN_LATCHED: outD = |(latchedStatus & words23);
            pfs_pkg::FN_MANUAL: outD = manualOut; // [R3]
            pfs_pkg::FN_TRAJ: outD = |(trajStatus & words23);
            pfs_pkg::FN_WINDOW: outD = inWindow;
            pfs_pkg::FN_CROSS_UP, pfs_pkg::FN_CROSS_DN, pfs_pkg::FN_CROSS_ANY,
            pfs_pkg::FN_TABLE: outD = pulseBusy || oneCycTrig || (lenTrig && words45 != 32'h0);
            pfs_pkg::FN_PHASE: outD = phaseAct; // [R5]
            pfs_pkg::FN_REGEN: outD = regenReq; // [R8]
            pfs_pkg::FN_SYNC: outD = syncRise; // [R9]
            pfs_pkg::FN_FRAME: outD = pinSync_q[1]; // [R10]
            pfs_pkg::FN_CAPTURE: outD = bit14 ? (pulseBusy || capTrig) : capAny; // [R11] [R13]
            pfs_pkg::FN_COMPARE: outD = pinSync_q[2]; // [R15]
            pfs_pkg::FN_EVT_MAN: outD = evtMan;
            pfs_pkg::FN_BRAKE: outD = brkOn; // [R19]
            default: outD = 1'b0; // [R22]
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            outActive <= `PFS_OUT_RST;
        end else if (clkEn) begin
            outActive <= outD;
        end
    end

endmodule

// ==== core/pfs_defines.svh ====
// constants for the programmable output function selector
`ifndef PFS_DEFINES_SVH
`define PFS_DEFINES_SVH

// configuration word fields
`define PFS_FUNC_LSB 0
`define PFS_FUNC_MSB 4
`define PFS_BIT_ALT1 14
`define PFS_BIT_ALT2 15

// clock and time base
`define PFS_CLK_NS 10
`define PFS_US_NS 1000
`define PFS_MS_NS 1000000
`define PFS_US_CYCLES (`PFS_US_NS / `PFS_CLK_NS)
`define PFS_MS_CYCLES (`PFS_MS_NS / `PFS_CLK_NS)

// phase angle arithmetic
`define PFS_DEG_FULL 10'h168
`define PFS_DEG_HALF 10'h0b4

// reset values
`define PFS_OUT_RST 1'b0
`define PFS_CLR_RST 32'h0000_0000

`endif

// ==== core/pfs_pkg.sv ====
// types shared by the output function selector
package pfs_pkg;

    typedef enum logic [4:0] {
        FN_EVENT    = 5'h00,
        FN_LATCHED  = 5'h01,
        FN_MANUAL   = 5'h02,
        FN_TRAJ     = 5'h03,
        FN_WINDOW   = 5'h04,
        FN_CROSS_UP = 5'h05,
        FN_CROSS_DN = 5'h06,
        FN_CROSS_ANY= 5'h07,
        FN_PHASE    = 5'h08,
        FN_TABLE    = 5'h09,
        FN_REGEN    = 5'h0a,
        FN_SYNC     = 5'h0b,
        FN_FRAME    = 5'h0c,
        FN_CAPTURE  = 5'h0d,
        FN_COMPARE  = 5'h10,
        FN_EVT_MAN  = 5'h11,
        FN_BRAKE    = 5'h12
    } pfs_func_e;

    typedef enum logic [1:0] {
        BRK_IDLE = 2'b00,
        BRK_HOLD = 2'b01,
        BRK_PWM  = 2'b10
    } pfs_brake_e;

endpackage

// ==== verif/pfs_load_model.sv ====
// load model: external brake or regen resistor switched by the selected output
module pfs_load_model (
    // clock
    input wire logic clk,
    // drive from the selector
    input wire logic outActive,
    // load state
    output logic loadOn
);
    timeunit 1ns;
    timeprecision 1ps;
    // the load contactor follows its drive one clock late
    always_ff @(posedge clk) begin
        loadOn <= outActive;
    end
endmodule

// ==== verif/pfs_output_select_chk.sv ====
// concurrent checks on the output function selector ports
module pfs_output_select_chk (
    // clock, reset, enable
    input wire logic clk,
    input wire logic rst,
    input wire logic clkEn,
    // configuration and sources
    input wire logic [15:0] cfgWord,
    input wire logic [15:0] extraWord1,
    input wire logic [15:0] extraWord2,
    input wire logic [15:0] extraWord3,
    input wire logic [8:0] phaseDeg,
    input wire logic [31:0] eventStatus,
    input wire logic [31:0] captureStatus,
    input wire logic manualOut,
    input wire logic frameRxPin,
    input wire logic compareHitPin,
    // results
    input wire logic outActive,
    input wire logic [31:0] captureClear
);
    timeunit 1ns;
    timeprecision 1ps;
    wire logic [4:0] fn = cfgWord[4:0];
    wire logic [31:0] mask = {extraWord3, extraWord2};
    wire logic [9:0] phSum = 10'(phaseDeg) + 10'(extraWord1 % 16'h0168);
    wire logic phOn = ((phSum >= 10'h168) ? (phSum - 10'h168) : phSum) < 10'h0b4;
    wire logic evt = |(eventStatus & mask);
    wire logic undef = (fn == 5'h0e) || (fn == 5'h0f) || (fn > 5'h12);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////
    a_manual_follow: assert property (
        clkEn && fn == 5'h02 |=> outActive == $past(manualOut)) else $error("manual output not followed");
    a_undef_idle: assert property (
        clkEn && undef |=> !outActive) else $error("undefined code drove output");
    a_evtman_sel: assert property (
        clkEn && fn == 5'h11 |=> outActive == $past(evt ? !cfgWord[14] : manualOut ? !cfgWord[15] : cfgWord[15]))
        else $error("event or manual selection wrong");
    a_phase_win: assert property (
        clkEn && fn == 5'h08 |=> outActive == $past(phOn)) else $error("phase window wrong");
    a_capture_level: assert property (
        clkEn && fn == 5'h0d && !cfgWord[14] |=> outActive == $past(|(captureStatus & mask)))
        else $error("capture tracking wrong");
    a_capture_clear: assert property (
        $past(clkEn) && captureClear != 32'h0 |-> captureClear == $past(captureStatus & mask) ##1 outActive)
        else $error("capture clear wrong");
    a_frame_sync: assert property (
        (clkEn && fn == 5'h0c) [*4] |-> outActive == $past(frameRxPin, 3)) else $error("frame output wrong");
    a_compare_sync: assert property (
        (clkEn && fn == 5'h10) [*4] |-> outActive == $past(compareHitPin, 3)) else $error("compare output wrong");
    c_cross: cover property (fn == 5'h05 && outActive);
    c_clear: cover property (captureClear != 32'h0);
    c_brake: cover property (fn == 5'h12 && outActive);
endmodule
bind pfs_output_select pfs_output_select_chk chk_u (.clk(clk), .rst(rst), .clkEn(clkEn), .cfgWord(cfgWord),
    .extraWord1(extraWord1), .extraWord2(extraWord2), .extraWord3(extraWord3), .phaseDeg(phaseDeg),
    .eventStatus(eventStatus), .captureStatus(captureStatus), .manualOut(manualOut), .frameRxPin(frameRxPin),
    .compareHitPin(compareHitPin), .outActive(outActive), .captureClear(captureClear));

// ==== verif/tb_top.sv ====
// self-checking testbench for the output function selector
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, rst = 1'b1, servoTick = 1'b0, manualOut = 1'b0, regenReq = 1'b0, brakeReq = 1'b0;
    logic tblWrEn = 1'b0, syncPin = 1'b0, frameRxPin = 1'b0, compareHitPin = 1'b0, clkEn = 1'b1, outActive, loadOn;
    logic [15:0] cfgWord = 16'h0000, w1 = 16'h0000, w2 = 16'h0000, w3 = 16'h0000, w4 = 16'h0000, w5 = 16'h0000;
    logic [31:0] cmdPos = 32'h0, actPos = 32'h0, eventStatus = 32'h0, captureStatus = 32'h0, captureClear;
    logic [8:0] phaseDeg = 9'h000;
    logic [2:0] tblWrAddr = 3'h0;
    logic [3:0] tblCount = 4'h0;
    int errors = 0, n_tests = 0, cnt;
    pfs_output_select #(.MS_CYCLES(20), .US_CYCLES(4)) dut_u (.clk(clk), .rst(rst), .clkEn(clkEn),
        .cfgWord(cfgWord), .extraWord1(w1), .extraWord2(w2), .extraWord3(w3), .extraWord4(w4), .extraWord5(w5),
        .servoTick(servoTick), .cmdPos(cmdPos), .actPos(actPos), .phaseDeg(phaseDeg), .eventStatus(eventStatus),
        .latchedStatus(32'h0), .trajStatus(32'h0), .captureStatus(captureStatus), .manualOut(manualOut),
        .regenReq(regenReq), .brakeReq(brakeReq), .tblWrEn(tblWrEn), .tblWrAddr(tblWrAddr),
        .tblWrData(32'h0000_0300), .tblCount(tblCount), .syncPin(syncPin), .frameRxPin(frameRxPin),
        .compareHitPin(compareHitPin), .outActive(outActive), .captureClear(captureClear));
    pfs_load_model load_u (.clk(clk), .outActive(outActive), .loadOn(loadOn));
    ////////////////////////////////////////////////////////////////
    task automatic report_and_stop;
        $display("errors %0d n_tests %0d", errors, n_tests);
        if (errors == 0 && n_tests > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic tick;
        servoTick = 1'b1;
        cyc(1);
        servoTick = 1'b0;
    endtask
    task automatic setc(input logic [15:0] c, input logic [15:0] a2, input logic [15:0] a4);
        cfgWord = c;
        w2 = a2;
        w4 = a4;
    endtask
    // count cycles with the output high over a span
    task automatic highs(input int n);
        cnt = 0;
        repeat (n) begin
            cyc(1);
            cnt += int'(outActive === 1'b1);
        end
    endtask
    ////////////////////////////////////////////////////////////////
    task automatic t_levels;
        logic [3:0] i;
        setc(16'h0002, 16'h0001, 16'h0000);
        manualOut = 1'b1;
        cyc(2);
        chk(outActive, 1);
        // enable low freezes the output although the manual bit drops
        clkEn = 1'b0;
        manualOut = 1'b0;
        cyc(2);
        chk(outActive, 1);
        clkEn = 1'b1;
        cyc(2);
        chk(outActive, 0);
        cfgWord = 16'h001f;
        cyc(2);
        chk(outActive, 0);
        setc(16'h0000, 16'h0100, 16'h0000);
        eventStatus = 32'h0000_0100;
        cyc(2);
        chk(outActive, 1);
        w2 = 16'h0001;
        for (int k = 0; k < 16; k++) begin
            i = 4'(k);
            cfgWord = {i[0], i[1], 14'h0011};
            eventStatus = {31'h0, i[3]};
            manualOut = i[2];
            cyc(2);
            chk(outActive, i[3] ? !i[1] : i[2] ? !i[0] : i[0]);
        end
    endtask
    task automatic t_phase;
        logic [8:0] ang [4] = '{9'h000, 9'h0aa, 9'h09f, 9'h0a0};
        logic exp [4] = '{1'b0, 1'b1, 1'b0, 1'b1};
        setc(16'h0008, 16'h0000, 16'h0000);
        w1 = 16'h00c8;
        for (int k = 0; k < 4; k++) begin
            phaseDeg = ang[k];
            cyc(2);
            chk(outActive, exp[k]);
        end
    endtask
    task automatic t_cross;
        // position window 100..200, commanded then actual position
        setc(16'h4004, 16'h0064, 16'h00c8);
        cmdPos = 32'h0000_0096;
        cyc(2);
        chk(outActive, 1);
        cfgWord = 16'h0004;
        cyc(2);
        chk(outActive, 0);
        cmdPos = 32'h0;
        setc(16'h4005, 16'h0064, 16'h0000);
        actPos = 32'h0000_00c8;
        tick();
        cmdPos = 32'h0000_00c8;
        actPos = 32'h0;
        tick();
        chk(outActive, 1);
        cyc(5);
        chk(outActive, 1);
        tick();
        cyc(1);
        chk(outActive, 0);
        actPos = 32'h0000_00c8;
        tick();
        cyc(1);
        chk(outActive, 0);
        setc(16'h4007, 16'h0064, 16'h0002);
        cmdPos = 32'h0;
        tick();
        cyc(15);
        chk(outActive, 1);
        cyc(30);
        chk(outActive, 0);
        setc(16'h4009, 16'h0000, 16'h0000);
        tblWrEn = 1'b1;
        tblCount = 4'h1;
        cyc(1);
        tblWrEn = 1'b0;
        cmdPos = 32'h0000_0400;
        tick();
        chk(outActive, 1);
        tick();
        cyc(1);
        chk(outActive, 0);
        // falling crossing on commanded position
        setc(16'h4006, 16'h0064, 16'h0000);
        cmdPos = 32'h0;
        tick();
        chk(outActive, 1);
        tick();
        cyc(1);
        chk(outActive, 0);
    endtask
    task automatic t_capture;
        setc(16'h000d, 16'h0005, 16'h0000);
        captureStatus = 32'h4;
        cyc(2);
        chk(outActive, 1);
        captureStatus = 32'h2;
        cyc(2);
        chk(outActive, 0);
        cfgWord = 16'h400d;
        captureStatus = 32'h6;
        cyc(1);
        chk(captureClear, 32'h4);
        captureStatus = 32'h0;
        cyc(1);
        chk(outActive, 1);
        tick();
        cyc(1);
        chk(outActive, 0);
        // two millisecond pulse: at least 20 and at most 41 cycles high
        setc(16'h400d, 16'h0005, 16'h0002);
        captureStatus = 32'h4;
        cyc(1);
        chk(captureClear, 32'h4);
        captureStatus = 32'h0;
        highs(20);
        chk(cnt, 20);
        cyc(25);
        chk(outActive, 0);
    endtask
    task automatic t_pins;
        setc(16'h000c, 16'h0000, 16'h0000);
        frameRxPin = 1'b1;
        cyc(4);
        chk(outActive, 1);
        cfgWord = 16'h0010;
        compareHitPin = 1'b1;
        frameRxPin = 1'b0;
        cyc(4);
        chk(outActive, 1);
        compareHitPin = 1'b0;
        cyc(4);
        chk(outActive, 0);
        cfgWord = 16'h000b;
        syncPin = 1'b1;
        highs(8);
        chk(cnt, 1);
        cfgWord = 16'h000a;
        regenReq = 1'b1;
        cyc(3);
        chk(loadOn, 1);
    endtask
    task automatic t_brake;
        setc(16'h0012, 16'h0002, 16'h0000);
        w3 = 16'h0004;
        w5 = 16'h0003;
        brakeReq = 1'b1;
        cyc(3);
        chk(outActive, 1);
        // three millisecond hold lasts at least 40 cycles before switching
        highs(36);
        chk(cnt, 36);
        cyc(30);
        highs(32);
        chk(cnt, 16);
        brakeReq = 1'b0;
        cyc(2);
        chk(outActive, 0);
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        forever #5 clk = ~clk;
    end
    initial begin
        #100000;
        errors++;
        report_and_stop();
    end
    initial begin
        cyc(6);
        rst = 1'b0;
        t_levels();
        t_phase();
        t_cross();
        t_capture();
        t_pins();
        t_brake();
        report_and_stop();
    end
endmodule
